//--- design/pws_map.vh
/*
 * Constants for the well-state sequencer: state codes, stop causes
 * and fixed timing figures.
 * Assumes inclusion by bare name from the sequencer and the test bench.
 */
`ifndef PWS_MAP_VH
`define PWS_MAP_VH

// Clock rate
`define PWS_CLK_HZ        40000000

// Well state codes
`define PWS_ST_INIT       5'h0_0
`define PWS_ST_PWR_DLY    5'h0_1
`define PWS_ST_ALERT      5'h0_2
`define PWS_ST_STARTING   5'h0_3
`define PWS_ST_MIN_STRK   5'h0_4
`define PWS_ST_PUMP_NORM  5'h0_5
`define PWS_ST_PUMP_HOST  5'h0_6
`define PWS_ST_PUMP_TIMED 5'h0_7
`define PWS_ST_CALIB      5'h0_8
`define PWS_ST_STOPPING   5'h0_9
`define PWS_ST_STOPPED    5'h0_A
`define PWS_ST_DT_PUMPOFF 5'h0_B
`define PWS_ST_DT_SETPT   5'h0_C
`define PWS_ST_DT_GLOBAL  5'h0_D
`define PWS_ST_DT_PEM     5'h0_E
`define PWS_ST_DT_HOST    5'h0_F
`define PWS_ST_DT_TIMED   5'h1_0
`define PWS_ST_MALF_SETPT 5'h1_1
`define PWS_ST_MALF_START 5'h1_2

// Stop causes
`define PWS_CS_PUMPOFF    3'h0
`define PWS_CS_SETPT      3'h1
`define PWS_CS_GLOBAL     3'h2
`define PWS_CS_PEM        3'h3
`define PWS_CS_HOST       3'h4
`define PWS_CS_TIMED      3'h5
`define PWS_CS_STARTFAIL  3'h6

// Timing, in seconds unless noted
`define PWS_BOOT_SECS     16'h0002
`define PWS_START_SECS    16'h000A
`define PWS_STILL_SECS    16'h0003
`define PWS_DWELL_CYC     4'h4

`endif

//--- design/pws_sec_timer.v
/*
 * Seconds countdown timer with its own prescaler.
 * Assumes load comes from the sequencer and may stand through reset.
 */
`timescale 1ns/1ps
`default_nettype none

module pws_sec_timer #(
	parameter TICKS_PER_SEC = 40000000,
	parameter PW            = 26,
	parameter W             = 16
) (
	input  wire         clk,
	input  wire         rst,
	input  wire         load,
	input  wire [W-1:0] secs,
	output wire         done
);

	localparam [31:0]   PRE_FULL = TICKS_PER_SEC - 1;
	localparam [PW-1:0] PRE_MAX  = PRE_FULL[PW-1:0];

	reg  [PW-1:0] pre_ff;
	reg  [W-1:0]  sec_ff;

	////////////////////////////////////////////////////////////////////////
	// Prescaler restarts on load so a full second is always counted
	always @(posedge clk) begin
		if (rst || load || pre_ff == PRE_MAX) begin
			pre_ff <= {PW{1'b0}};
		end else begin
			pre_ff <= pre_ff + 1'b1;
		end
	end

	always @(posedge clk) begin
		// Load wins over reset so the boot period is armed during reset
		if (load) begin
			sec_ff <= secs;
		end else if (rst) begin
			sec_ff <= {W{1'b0}};
		end else if (pre_ff == PRE_MAX && sec_ff != {W{1'b0}}) begin
			sec_ff <= sec_ff - 1'b1;
		end
	end

	assign done = (sec_ff == {W{1'b0}});

endmodule // pws_sec_timer

`default_nettype wire

//--- design/pws_sequencer.v
/*
 * Well-state sequencer for a rod pump controller.
 * Assumes all inputs synchronous to CLK_SYS; event inputs are levels
 * sampled while the matching state is active.
 */
// Notes on behaviour
// - Exactly one state, always shown on output
// - Pump-off, setpoint, PEM and timed downtimes auto-restart when downtime expires
// - Global off holds pump until run permit
// - Energy management downtime lasts its whole period
// - Malfunction states leave only on operator clear or reset button
// - Stopped is brief, then explains stop cause
// - Starting drives start low; position, then load
// - Minimum strokes run without dynagraph analysis
// - Normal pumping enables all monitoring functions
// - Host pumping when host mode and run
// - Timed pumping while timed mode runs
// - Bottom-of-stroke adjust shown as calibration state
// - Initializing at power-up and reset button
// - Power-on delay waits programmed seconds
// - Start alert drives alert low programmed seconds
// - Stopping until load and position static
// - Pumped-off stop enters pump-off downtime
// - Clean restart clears consecutive violation count
// - Allowed consecutive violations lead to malfunction
// - Start and alert outputs are active low; analysis enable is active high
`timescale 1ns/1ps
`default_nettype none
`include "pws_map.vh"

module pws_sequencer #(
	parameter TICKS_PER_SEC = `PWS_CLK_HZ,
	parameter SW            = 16,
	parameter LW            = 12,
	parameter CW            = 8
) (
	input  wire          CLK_SYS,
	input  wire          SYS_RST,
	input  wire          RESET_BTN,
	input  wire          POS_IN,
	input  wire [LW-1:0] LOAD_IN,
	input  wire [SW-1:0] PWR_DLY_SECS,
	input  wire          ALERT_EN,
	input  wire [SW-1:0] ALERT_SECS,
	input  wire [SW-1:0] DOWNTIME_SECS,
	input  wire [SW-1:0] PEM_SECS,
	input  wire [SW-1:0] TIMED_ON_SECS,
	input  wire [SW-1:0] TIMED_OFF_SECS,
	input  wire [SW-1:0] MIN_STROKES,
	input  wire [CW-1:0] MALF_ALLOWED,
	input  wire          HOST_MODE,
	input  wire          HOST_RUN,
	input  wire          TIMED_MODE,
	input  wire          GLOBAL_OFF,
	input  wire          RUN_PERMIT,
	input  wire          PEM_REQ,
	input  wire          CAL_REQ,
	input  wire          OPER_CLEAR,
	input  wire          PUMPOFF_DET,
	input  wire          SETPT_VIOL,
	output wire [4:0]    WELL_STATE,
	output wire          START_N,
	output wire          ALERT_N,
	output wire          ANALYSIS_EN,
	output wire [CW-1:0] MALF_COUNT
);

	reg  [4:0]    state_ff;
	reg  [4:0]    nxt_state;
	reg  [2:0]    cause_ff;
	reg  [2:0]    nxt_cause;
	reg           phase_ff;
	reg           nxt_phase;
	reg  [SW-1:0] strk_ff;
	reg  [SW-1:0] nxt_strk;
	reg  [CW-1:0] malf_ff;
	reg  [CW-1:0] nxt_malf;
	reg  [3:0]    dwell_ff;
	reg           pos_d_ff;
	reg  [LW-1:0] load_d_ff;
	reg           start_n_ff;
	reg           alert_n_ff;
	reg           analysis_ff;
	reg  [SW-1:0] tmr_secs;
	reg  [4:0]    start_st;
	wire          tmr_load;
	wire          tmr_done;
	wire          pos_edge;
	wire          load_chg;
	wire          motion;
	wire          running;
	wire [CW-1:0] malf_inc;

	assign pos_edge = POS_IN & ~pos_d_ff;
	assign load_chg = (LOAD_IN != load_d_ff);
	assign motion   = (POS_IN != pos_d_ff) | load_chg;
	assign malf_inc = malf_ff + 1'b1;
	assign running  = (state_ff == `PWS_ST_MIN_STRK) || (state_ff == `PWS_ST_PUMP_NORM) ||
		(state_ff == `PWS_ST_PUMP_HOST) || (state_ff == `PWS_ST_PUMP_TIMED);

	////////////////////////////////////////////////////////////////////////
	// Shared seconds timer, reloaded on every state change
	// Stopping reloads on motion, so done means inputs went static
	assign tmr_load = SYS_RST || RESET_BTN || (nxt_state != state_ff) ||
		(state_ff == `PWS_ST_STOPPING && motion) ||
		(state_ff == `PWS_ST_STARTING && nxt_phase != phase_ff);

	always @* begin
		case (SYS_RST ? `PWS_ST_INIT : nxt_state)
		`PWS_ST_INIT:       tmr_secs = `PWS_BOOT_SECS;
		`PWS_ST_PWR_DLY:    tmr_secs = PWR_DLY_SECS;
		`PWS_ST_ALERT:      tmr_secs = ALERT_SECS;
		`PWS_ST_STARTING:   tmr_secs = `PWS_START_SECS;
		`PWS_ST_STOPPING:   tmr_secs = `PWS_STILL_SECS;
		`PWS_ST_PUMP_TIMED: tmr_secs = TIMED_ON_SECS;
		`PWS_ST_DT_TIMED:   tmr_secs = TIMED_OFF_SECS;
		`PWS_ST_DT_PEM:     tmr_secs = PEM_SECS;
		default:            tmr_secs = DOWNTIME_SECS;
		endcase
	end

	pws_sec_timer #(
		.TICKS_PER_SEC (TICKS_PER_SEC),
		.W             (SW)
	) u_timer (
		.clk  (CLK_SYS),
		.rst  (SYS_RST),
		.load (tmr_load),
		.secs (tmr_secs),
		.done (tmr_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state
	always @* begin
		start_st  = ALERT_EN ? `PWS_ST_ALERT : `PWS_ST_STARTING;
		nxt_state = state_ff;
		nxt_cause = cause_ff;
		nxt_phase = phase_ff;
		nxt_strk  = strk_ff;
		nxt_malf  = malf_ff;
		case (state_ff)
		`PWS_ST_INIT: begin
			if (tmr_done) begin
				nxt_state = `PWS_ST_PWR_DLY;
			end
		end
		`PWS_ST_PWR_DLY: begin
			if (tmr_done) begin
				nxt_state = start_st;
			end
		end
		`PWS_ST_ALERT: begin
			if (tmr_done) begin
				nxt_state = `PWS_ST_STARTING;
			end
		end
		`PWS_ST_STARTING: begin
			// Position confirms first, then load; timeout per phase
			if (!phase_ff && pos_edge) begin
				nxt_phase = 1'b1;
			end else if (phase_ff && load_chg) begin
				nxt_phase = 1'b0;
				nxt_strk  = {SW{1'b0}};
				if (HOST_MODE) begin
					nxt_state = `PWS_ST_PUMP_HOST;
				end else if (TIMED_MODE) begin
					nxt_state = `PWS_ST_PUMP_TIMED;
				end else begin
					nxt_state = `PWS_ST_MIN_STRK;
				end
			end else if (tmr_done) begin
				nxt_phase = 1'b0;
				nxt_cause = `PWS_CS_STARTFAIL;
				nxt_state = `PWS_ST_STOPPING;
			end
		end
		`PWS_ST_MIN_STRK: begin
			if (pos_edge) begin
				nxt_strk = strk_ff + 1'b1;
			end
			if (strk_ff >= MIN_STROKES) begin
				nxt_strk  = {SW{1'b0}};
				nxt_state = `PWS_ST_PUMP_NORM;
			end
		end
		`PWS_ST_PUMP_NORM: begin
			if (pos_edge && strk_ff < MIN_STROKES) begin
				nxt_strk = strk_ff + 1'b1;
			end
			// A run of clean strokes after restart clears the count
			if (strk_ff >= MIN_STROKES) begin
				nxt_malf = {CW{1'b0}};
			end
			if (SETPT_VIOL) begin
				nxt_cause = `PWS_CS_SETPT;
				nxt_state = `PWS_ST_STOPPING;
			end else if (PUMPOFF_DET) begin
				nxt_cause = `PWS_CS_PUMPOFF;
				nxt_state = `PWS_ST_STOPPING;
			end
		end
		`PWS_ST_PUMP_HOST: begin
			if (!HOST_RUN) begin
				nxt_cause = `PWS_CS_HOST;
				nxt_state = `PWS_ST_STOPPING;
			end
		end
		`PWS_ST_PUMP_TIMED: begin
			if (tmr_done || !TIMED_MODE) begin
				nxt_cause = `PWS_CS_TIMED;
				nxt_state = `PWS_ST_STOPPING;
			end
		end
		`PWS_ST_STOPPING: begin
			if (tmr_done) begin
				nxt_state = `PWS_ST_STOPPED;
			end
		end
		`PWS_ST_STOPPED: begin
			if (dwell_ff == `PWS_DWELL_CYC) begin
				case (cause_ff)
				`PWS_CS_PUMPOFF:   nxt_state = `PWS_ST_DT_PUMPOFF;
				`PWS_CS_GLOBAL:    nxt_state = `PWS_ST_DT_GLOBAL;
				`PWS_CS_PEM:       nxt_state = `PWS_ST_DT_PEM;
				`PWS_CS_HOST:      nxt_state = `PWS_ST_DT_HOST;
				`PWS_CS_TIMED:     nxt_state = `PWS_ST_DT_TIMED;
				`PWS_CS_STARTFAIL: nxt_state = `PWS_ST_MALF_START;
				`PWS_CS_SETPT: begin
					nxt_malf = malf_inc;
					if (malf_inc >= MALF_ALLOWED) begin
						nxt_state = `PWS_ST_MALF_SETPT;
					end else begin
						nxt_state = `PWS_ST_DT_SETPT;
					end
				end
				default:           nxt_state = `PWS_ST_MALF_START;
				endcase
			end
		end
		`PWS_ST_DT_GLOBAL: begin
			if (RUN_PERMIT && !GLOBAL_OFF) begin
				nxt_state = start_st;
			end
		end
		`PWS_ST_DT_HOST: begin
			if (!HOST_MODE || HOST_RUN) begin
				nxt_state = start_st;
			end
		end
		`PWS_ST_DT_PEM: begin
			if (tmr_done) begin
				nxt_state = start_st;
			end
		end
		`PWS_ST_CALIB: begin
			if (!CAL_REQ) begin
				nxt_state = start_st;
			end
		end
		`PWS_ST_MALF_SETPT,
		`PWS_ST_MALF_START: begin
			if (OPER_CLEAR) begin
				nxt_malf  = {CW{1'b0}};
				nxt_state = start_st;
			end
		end
		`PWS_ST_DT_PUMPOFF,
		`PWS_ST_DT_SETPT,
		`PWS_ST_DT_TIMED: begin
			if (tmr_done) begin
				nxt_state = start_st;
			end
		end
		default: begin
			nxt_state = `PWS_ST_INIT;
		end
		endcase

		// Overrides that apply across groups of states
		if (running || state_ff == `PWS_ST_STARTING) begin
			if (GLOBAL_OFF) begin
				nxt_cause = `PWS_CS_GLOBAL;
				nxt_state = `PWS_ST_STOPPING;
			end else if (PEM_REQ) begin
				nxt_cause = `PWS_CS_PEM;
				nxt_state = `PWS_ST_STOPPING;
			end
		end else if (state_ff == `PWS_ST_DT_PUMPOFF || state_ff == `PWS_ST_DT_SETPT ||
				state_ff == `PWS_ST_DT_TIMED || state_ff == `PWS_ST_DT_HOST ||
				state_ff == `PWS_ST_PWR_DLY || state_ff == `PWS_ST_ALERT) begin
			// Pump already still, so no stopping pass is needed
			if (GLOBAL_OFF) begin
				nxt_state = `PWS_ST_DT_GLOBAL;
			end else if (PEM_REQ) begin
				nxt_state = `PWS_ST_DT_PEM;
			end else if (CAL_REQ) begin
				nxt_state = `PWS_ST_CALIB;
			end
		end
		if (RESET_BTN) begin
			nxt_state = `PWS_ST_INIT;
			nxt_phase = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State and outputs; outputs follow the next state so they line up
	always @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			state_ff    <= `PWS_ST_INIT;
			cause_ff    <= `PWS_CS_PUMPOFF;
			phase_ff    <= 1'b0;
			strk_ff     <= {SW{1'b0}};
			malf_ff     <= {CW{1'b0}};
			dwell_ff    <= 4'h0;
			pos_d_ff    <= 1'b0;
			load_d_ff   <= {LW{1'b0}};
			start_n_ff  <= 1'b1;
			alert_n_ff  <= 1'b1;
			analysis_ff <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			cause_ff    <= nxt_cause;
			phase_ff    <= nxt_phase;
			strk_ff     <= nxt_strk;
			malf_ff     <= nxt_malf;
			dwell_ff    <= (state_ff == `PWS_ST_STOPPED) ? dwell_ff + 1'b1 : 4'h0;
			pos_d_ff    <= POS_IN;
			load_d_ff   <= LOAD_IN;
			start_n_ff  <= ~(nxt_state == `PWS_ST_STARTING || nxt_state == `PWS_ST_MIN_STRK ||
				nxt_state == `PWS_ST_PUMP_NORM || nxt_state == `PWS_ST_PUMP_HOST ||
				nxt_state == `PWS_ST_PUMP_TIMED);
			alert_n_ff  <= ~(nxt_state == `PWS_ST_ALERT);
			analysis_ff <= (nxt_state == `PWS_ST_PUMP_NORM);
		end
	end

	assign WELL_STATE  = state_ff;
	assign START_N     = start_n_ff;
	assign ALERT_N     = alert_n_ff;
	assign ANALYSIS_EN = analysis_ff;
	assign MALF_COUNT  = malf_ff;

endmodule // pws_sequencer

`default_nettype wire

//--- verif/pws_seq_assertions.sv
/* Port checker for the well-state sequencer, bound after the module.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none

module pws_seq_assertions #(parameter CW = 8) (
	input wire logic          CLK_SYS,
	input wire logic          SYS_RST,
	input wire logic          RESET_BTN,
	input wire logic          SETPT_VIOL,
	input wire logic          GLOBAL_OFF,
	input wire logic          OPER_CLEAR,
	input wire logic [4:0]    WELL_STATE,
	input wire logic          START_N,
	input wire logic          ALERT_N,
	input wire logic          ANALYSIS_EN,
	input wire logic [CW-1:0] MALF_COUNT
);
default clocking @(posedge CLK_SYS); endclocking
default disable iff (SYS_RST);
wire logic run = WELL_STATE >= 5'h0_3 && WELL_STATE <= 5'h0_7;
////////////////////////////////////////////////////////////////////////////////
a_state_legal: assert property (WELL_STATE <= 5'h1_2)
	else $error("state code out of range");
a_start_run: assert property (START_N == !run)
	else $error("start output disagrees with state");
a_alert_only: assert property (ALERT_N == (WELL_STATE != 5'h0_2))
	else $error("alert output disagrees with state");
a_analysis_norm: assert property (ANALYSIS_EN == (WELL_STATE == 5'h0_5))
	else $error("analysis enable disagrees with state");
a_button_init: assert property (RESET_BTN |=> WELL_STATE == 5'h0_0)
	else $error("button did not force init");
// Window is loose by one edge either way on the five-edge stay in stopped
a_stop_brief: assert property ($rose(WELL_STATE == 5'h0_A) |-> ##[4:6] WELL_STATE != 5'h0_A)
	else $error("stopped state did not pass on");
a_malf_hold: assert property (WELL_STATE == 5'h1_1 && !OPER_CLEAR && !RESET_BTN
	|=> WELL_STATE == 5'h1_1)
	else $error("malfunction left without operator");
a_global_hold: assert property (WELL_STATE == 5'h0_D && GLOBAL_OFF && !RESET_BTN
	|=> WELL_STATE == 5'h0_D)
	else $error("global off released early");
a_viol_stop: assert property (WELL_STATE == 5'h0_5 && SETPT_VIOL && !RESET_BTN
	|=> WELL_STATE == 5'h0_9 && START_N && !ANALYSIS_EN)
	else $error("violation did not start stopping");
a_count_step: assert property ($changed(MALF_COUNT)
	|-> MALF_COUNT == $past(MALF_COUNT) + 1'b1 || MALF_COUNT == '0)
	else $error("violation count jumped");
c_malf: cover property (WELL_STATE == 5'h1_1);
c_start_fail: cover property (WELL_STATE == 5'h1_2);
c_global: cover property (WELL_STATE == 5'h0_D);
c_calib: cover property (WELL_STATE == 5'h0_8);
endmodule // pws_seq_assertions

bind pws_sequencer pws_seq_assertions #(.CW(CW)) i_chk (.CLK_SYS(CLK_SYS),
	.SYS_RST(SYS_RST), .RESET_BTN(RESET_BTN), .SETPT_VIOL(SETPT_VIOL),
	.GLOBAL_OFF(GLOBAL_OFF), .OPER_CLEAR(OPER_CLEAR), .WELL_STATE(WELL_STATE),
	.START_N(START_N), .ALERT_N(ALERT_N), .ANALYSIS_EN(ANALYSIS_EN),
	.MALF_COUNT(MALF_COUNT));
`default_nettype wire

//--- verif/pws_pump_unit.sv
/* Pumping unit model: crank sensor and load follow the starter line.
   Assumes an active-low start line and the sequencer clock. */
`timescale 1ns/1ps
`default_nettype none

module pws_pump_unit (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start_n,
	input  wire logic        stuck,
	output logic             pos,
	output logic [11:0]      load
);
logic [7:0] phase_ff;
// Stuck unit never turns, so a start check must time out
always @(posedge clk) begin
	if (rst)
		phase_ff <= 8'h00;
	else if (!start_n && !stuck)
		phase_ff <= phase_ff + 8'h01;
end
// Load moves at once, crank rises later; both freeze when stopped
assign pos = phase_ff[2];
assign load = {phase_ff, 4'h3};
endmodule // pws_pump_unit
`default_nettype wire

//--- verif/test_pws_sequencer.sv
/* Self-checking bench for the well-state sequencer.
   Assumes ten ticks per second and the pumping unit model. */
`timescale 1ns/1ps
`default_nettype none
`include "pws_map.vh"

module test_pws_sequencer;
logic        clk_sys, sys_rst, reset_btn, alert_en, host_mode, host_run, timed_mode;
logic        global_off, run_permit, pem_req, cal_req, oper_clear, pumpoff_det;
logic        setpt_viol, stuck, pos, start_n, alert_n, analysis_en;
logic [11:0] load;
logic [15:0] secs, min_strokes;
logic [7:0]  malf_allowed, malf_count;
logic [4:0]  st;
integer      num_errors, n_checks;
////////////////////////////////////////////////////////////////////////////////
pws_sequencer #(.TICKS_PER_SEC(10)) i_dut (
	.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .RESET_BTN(reset_btn), .POS_IN(pos),
	.LOAD_IN(load), .PWR_DLY_SECS(secs), .ALERT_EN(alert_en), .ALERT_SECS(secs),
	.DOWNTIME_SECS(secs), .PEM_SECS(16'h0003), .TIMED_ON_SECS(secs),
	.TIMED_OFF_SECS(secs), .MIN_STROKES(min_strokes), .MALF_ALLOWED(malf_allowed),
	.HOST_MODE(host_mode), .HOST_RUN(host_run), .TIMED_MODE(timed_mode),
	.GLOBAL_OFF(global_off), .RUN_PERMIT(run_permit), .PEM_REQ(pem_req),
	.CAL_REQ(cal_req), .OPER_CLEAR(oper_clear), .PUMPOFF_DET(pumpoff_det),
	.SETPT_VIOL(setpt_viol), .WELL_STATE(st), .START_N(start_n),
	.ALERT_N(alert_n), .ANALYSIS_EN(analysis_en), .MALF_COUNT(malf_count));
pws_pump_unit i_unit (.clk(clk_sys), .rst(sys_rst), .start_n(start_n),
	.stuck(stuck), .pos(pos), .load(load));
////////////////////////////////////////////////////////////////////////////////
task tick;
	begin
		@(posedge clk_sys);
		#2;
	end
endtask
task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
	begin
		n_checks = n_checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	end
endtask
task report_and_stop;
	begin
		if (num_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
endtask
// Bounded wait; a miss ends the run
task wait_st(input logic [4:0] s, input integer n);
	integer i;
	begin
		for (i = 0; i < n && st !== s; i = i + 1)
			tick;
		chk("state", {3'h0, s}, {3'h0, st});
		if (st !== s)
			report_and_stop;
	end
endtask
task viol(input logic [4:0] s, input logic [7:0] c);
	begin
		setpt_viol = 1'h1;
		tick;
		setpt_viol = 1'h0;
		wait_st(`PWS_ST_STOPPING, 1);
		wait_st(`PWS_ST_STOPPED, 60);
		wait_st(s, 8);
		chk("count", c, malf_count);
	end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	clk_sys = 1'h0;
	forever #12.5 clk_sys = ~clk_sys;
end
initial begin
	{reset_btn, host_mode, host_run, timed_mode, global_off, run_permit} = 6'h00;
	{pem_req, cal_req, oper_clear, pumpoff_det, setpt_viol, stuck} = 6'h00;
	{sys_rst, alert_en, secs, min_strokes, malf_allowed} = {2'h3, 16'h0002, 16'h0003, 8'h02};
	num_errors = 0;
	n_checks = 0;
	repeat (5) tick;
	wait_st(`PWS_ST_INIT, 0);
	chk("start_n", 8'h01, {7'h0, start_n});
	sys_rst = 1'h0;
	repeat (15) tick;
	wait_st(`PWS_ST_INIT, 0);
	wait_st(`PWS_ST_PWR_DLY, 30);
	wait_st(`PWS_ST_ALERT, 30);
	chk("alert_n", 8'h00, {7'h0, alert_n});
	wait_st(`PWS_ST_STARTING, 30);
	chk("start_n", 8'h00, {7'h0, start_n});
	wait_st(`PWS_ST_MIN_STRK, 110);
	chk("analysis", 8'h00, {7'h0, analysis_en});
	wait_st(`PWS_ST_PUMP_NORM, 60);
	chk("analysis", 8'h01, {7'h0, analysis_en});
	viol(`PWS_ST_DT_SETPT, 8'h01);
	cal_req = 1'h1;
	wait_st(`PWS_ST_CALIB, 4);
	cal_req = 1'h0;
	wait_st(`PWS_ST_PUMP_NORM, 300);
	repeat (40) tick;
	chk("count", 8'h00, malf_count);
	viol(`PWS_ST_DT_SETPT, 8'h01);
	wait_st(`PWS_ST_ALERT, 30);
	wait_st(`PWS_ST_PUMP_NORM, 200);
	viol(`PWS_ST_MALF_SETPT, 8'h02);
	repeat (100) tick;
	wait_st(`PWS_ST_MALF_SETPT, 0);
	oper_clear = 1'h1;
	tick;
	oper_clear = 1'h0;
	wait_st(`PWS_ST_ALERT, 4);
	chk("count", 8'h00, malf_count);
	wait_st(`PWS_ST_PUMP_NORM, 200);
	pumpoff_det = 1'h1;
	tick;
	pumpoff_det = 1'h0;
	wait_st(`PWS_ST_DT_PUMPOFF, 60);
	wait_st(`PWS_ST_PUMP_NORM, 300);
	pem_req = 1'h1;
	wait_st(`PWS_ST_DT_PEM, 60);
	pem_req = 1'h0;
	// Past the ordinary downtime, so only the longer period can hold here
	repeat (25) tick;
	wait_st(`PWS_ST_DT_PEM, 0);
	wait_st(`PWS_ST_ALERT, 20);
	wait_st(`PWS_ST_PUMP_NORM, 200);
	global_off = 1'h1;
	wait_st(`PWS_ST_DT_GLOBAL, 60);
	{host_mode, host_run} = 2'h3;
	repeat (100) tick;
	wait_st(`PWS_ST_DT_GLOBAL, 0);
	{global_off, run_permit} = 2'h1;
	wait_st(`PWS_ST_ALERT, 4);
	run_permit = 1'h0;
	wait_st(`PWS_ST_PUMP_HOST, 150);
	host_run = 1'h0;
	wait_st(`PWS_ST_DT_HOST, 60);
	{host_mode, timed_mode} = 2'h1;
	wait_st(`PWS_ST_PUMP_TIMED, 150);
	wait_st(`PWS_ST_DT_TIMED, 80);
	wait_st(`PWS_ST_PUMP_TIMED, 150);
	// Alert skipped and a unit that never turns
	{timed_mode, alert_en, stuck, reset_btn} = 4'h3;
	tick;
	reset_btn = 1'h0;
	wait_st(`PWS_ST_INIT, 0);
	wait_st(`PWS_ST_PWR_DLY, 30);
	wait_st(`PWS_ST_STARTING, 24);
	wait_st(`PWS_ST_MALF_START, 300);
	chk("start_n", 8'h01, {7'h0, start_n});
	report_and_stop;
end
endmodule // test_pws_sequencer
`default_nettype wire
